// ### core/fault_event_recorder.v
// Fault event recorder with APB register access and a 20-entry record store
// Functional notes
// - Rising combined pickup opens a new fault record.
// - Combined pickup is the OR of all module pickups.
// - Combined trip is the OR of all module trips.
// - Measured values latched at the first trip of the fault.
// - Nonzero capture delay postpones the snapshot after the trip.
// - Alarms-and-trips mode commits every pickup episode.
// - Trips-only mode discards episodes that end without trip.
// - Display notification raised when a fault record is committed.
// - Fault duration is pickup rise to pickup fall.
// - Time to trip is first pickup to first trip.
// - Differing first pickup and trip modules mark time to trip unavailable.
// - Fault sequence counter increments per episode, stored in record.
// - Grid fault counter increments per episode except auto-reclose, stored.
// - Store holds at most twenty records.
// - Full store overwrites the oldest record first.
// - Newest record kept in a separate retained copy; the code clears this copy on reset.
// - Record holds first module to pick up.
// - Record holds first module to trip.
// - Record holds a tripped flag.
// - Record holds active parameter set index.
// - Record holds active adaptive group when adaptive sets used.
// - Record holds date and time stamp from the time base.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "fault_rec_defs.vh"

module fault_event_recorder #(
  parameter N_MOD = 16,
  parameter ID_W = 4,
  parameter SET_W = 2,
  parameter ADAPT_W = 4,
  parameter DEPTH = `REC_DEPTH,
  parameter TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
)(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [N_MOD-1:0] pickup_in,
  input wire [N_MOD-1:0] trip_in,
  input wire [31:0] meas_in,
  input wire [31:0] time_base,
  input wire [SET_W-1:0] param_set,
  input wire [ADAPT_W-1:0] active_adaptive_group,
  input wire adaptive_used,
  input wire auto_reclose,
  output reg comb_pickup,
  output reg comb_trip,
  output reg notify
);

  // ************************************************************
  // States
  // ************************************************************
  localparam S_IDLE = 3'b001;
  localparam S_PICKED = 3'b010;
  localparam S_WAITCAP = 3'b100;
  localparam PTR_W = 5;
  localparam [PTR_W-1:0] DEPTH_P = DEPTH;
  localparam [PTR_W-1:0] PTR_ONE = 5'h01;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  function [ID_W-1:0] first_set;
    input [N_MOD-1:0] v;
    integer k;
    begin
      first_set = {ID_W{1'b0}};
      for (k = N_MOD - 1; k >= 0; k = k - 1)
        if (v[k])
          first_set = k[ID_W-1:0];
    end
  endfunction

  // ************************************************************
  // Registers and record storage
  // ************************************************************
  reg [2:0] state_reg;
  reg mode_reg;
  reg [15:0] delay_reg;
  reg [7:0] select_reg;
  reg [31:0] tick_cnt_reg;
  reg tick_reg;
  reg [15:0] seq_reg;
  reg [15:0] grid_reg;
  reg [31:0] dur_reg;
  reg [31:0] ttt_reg;
  reg [15:0] cap_cnt_reg;
  reg cap_pend_reg;
  reg tripped_reg;
  reg [ID_W-1:0] pu_id_reg;
  reg [ID_W-1:0] tr_id_reg;
  reg ttt_ok_reg;
  reg [31:0] stamp_reg;
  reg [31:0] meas_reg;
  reg [31:0] cur_info_reg;
  reg [PTR_W-1:0] wr_ptr_reg;
  reg [PTR_W-1:0] count_reg;
  reg [31:0] info_mem [0:DEPTH-1];
  reg [31:0] cnt_mem [0:DEPTH-1];
  reg [31:0] stamp_mem [0:DEPTH-1];
  reg [31:0] dur_mem [0:DEPTH-1];
  reg [31:0] ttt_mem [0:DEPTH-1];
  reg [31:0] meas_mem [0:DEPTH-1];
  reg [31:0] nv_info_reg;
  reg [31:0] nv_cnt_reg;
  reg [31:0] nv_stamp_reg;
  reg [31:0] nv_dur_reg;
  reg [31:0] nv_ttt_reg;
  reg [31:0] nv_meas_reg;

  wire any_pu = |pickup_in;
  wire any_tr = |trip_in;
  wire pu_rise = any_pu & ~comb_pickup;
  wire pu_fall = ~any_pu & comb_pickup;
  wire first_trip = (state_reg == S_PICKED) & any_pu & any_tr & ~tripped_reg;
  wire [ID_W-1:0] tr_id_now = first_set(trip_in);
  wire cap_now = first_trip & (delay_reg == `DELAY_RESET);
  wire cap_late = cap_pend_reg & tick_reg & (cap_cnt_reg == 16'h0001);
  wire capture = cap_now | cap_late;
  wire keep = tripped_reg | mode_reg;
  wire cap_busy = cap_pend_reg & ~cap_late;
  wire commit_fall = (state_reg == S_PICKED) & pu_fall & keep & ~cap_busy & ~first_trip;
  wire commit_wait = (state_reg == S_WAITCAP) & cap_late;
  wire commit = commit_fall | commit_wait;
  wire [31:0] meas_word = capture ? meas_in : meas_reg;
  wire [31:0] info_word = {cur_info_reg[31:`INFO_TTT_OK_BIT+1], ttt_ok_reg, tripped_reg,
                           cur_info_reg[`INFO_TRIPPED_BIT-1:0]};
  wire [31:0] cnt_word = {grid_reg, seq_reg};
  wire [31:0] dur_word = dur_reg;

  // ************************************************************
  // Tick divider
  // ************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg >= TICK_LAST)
    begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      tick_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Fault sequencing
  // ************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= S_IDLE;
      comb_pickup <= 1'b0;
      comb_trip <= 1'b0;
      seq_reg <= `SEQ_RESET;
      grid_reg <= `SEQ_RESET;
      dur_reg <= 32'h00000000;
      ttt_reg <= 32'h00000000;
      cap_cnt_reg <= 16'h0000;
      cap_pend_reg <= 1'b0;
      tripped_reg <= 1'b0;
      pu_id_reg <= {ID_W{1'b0}};
      tr_id_reg <= {ID_W{1'b0}};
      ttt_ok_reg <= 1'b0;
      stamp_reg <= 32'h00000000;
      meas_reg <= 32'h00000000;
      cur_info_reg <= 32'h00000000;
    end
    else
    begin
      comb_pickup <= any_pu;
      comb_trip <= any_tr;
      if (capture)
        meas_reg <= meas_in;
      if (cap_pend_reg & tick_reg)
      begin
        cap_cnt_reg <= cap_cnt_reg - 16'h0001;
        if (cap_cnt_reg == 16'h0001)
          cap_pend_reg <= 1'b0;
      end
      case (state_reg)
        S_IDLE:
        begin
          if (pu_rise)
          begin
            state_reg <= S_PICKED;
            seq_reg <= seq_reg + 16'h0001;
            if (!auto_reclose)
              grid_reg <= grid_reg + 16'h0001;
            stamp_reg <= time_base;
            pu_id_reg <= first_set(pickup_in);
            dur_reg <= 32'h00000000;
            ttt_reg <= 32'h00000000;
            tripped_reg <= 1'b0;
            ttt_ok_reg <= 1'b0;
            meas_reg <= 32'h00000000;
            cur_info_reg <= 32'h00000000;
            cur_info_reg[`INFO_PU_LSB +: ID_W] <= first_set(pickup_in);
            cur_info_reg[`INFO_SET_LSB +: SET_W] <= param_set;
            if (adaptive_used)
            begin
              cur_info_reg[`INFO_ADAPT_LSB +: ADAPT_W] <= active_adaptive_group;
              cur_info_reg[`INFO_ADAPT_USED_BIT] <= 1'b1;
            end
          end
        end
        S_PICKED:
        begin
          if (tick_reg && dur_reg != 32'hFFFFFFFF)
            dur_reg <= dur_reg + 32'h00000001;
          if (tick_reg && !tripped_reg && ttt_reg != 32'hFFFFFFFF)
            ttt_reg <= ttt_reg + 32'h00000001;
          if (first_trip)
          begin
            tripped_reg <= 1'b1;
            tr_id_reg <= tr_id_now;
            cur_info_reg[`INFO_TR_LSB +: ID_W] <= tr_id_now;
            ttt_ok_reg <= (tr_id_now == pu_id_reg);
            if (delay_reg != `DELAY_RESET)
            begin
              cap_pend_reg <= 1'b1;
              cap_cnt_reg <= delay_reg;
            end
          end
          if (pu_fall && !first_trip)
          begin
            if (!keep)
              state_reg <= S_IDLE;
            else if (cap_busy)
              state_reg <= S_WAITCAP;
            else
              state_reg <= S_IDLE;
          end
        end
        S_WAITCAP:
        begin
          if (cap_late)
            state_reg <= S_IDLE;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Record store, oldest overwritten when full
  // ************************************************************
  always @(posedge pclk)
  begin
    if (commit)
    begin
      info_mem[wr_ptr_reg] <= info_word;
      cnt_mem[wr_ptr_reg] <= cnt_word;
      stamp_mem[wr_ptr_reg] <= stamp_reg;
      dur_mem[wr_ptr_reg] <= dur_word;
      ttt_mem[wr_ptr_reg] <= ttt_reg;
      meas_mem[wr_ptr_reg] <= meas_word;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      count_reg <= {PTR_W{1'b0}};
      nv_info_reg <= 32'h00000000;
      nv_cnt_reg <= 32'h00000000;
      nv_stamp_reg <= 32'h00000000;
      nv_dur_reg <= 32'h00000000;
      nv_ttt_reg <= 32'h00000000;
      nv_meas_reg <= 32'h00000000;
    end
    else if (commit)
    begin
      wr_ptr_reg <= (wr_ptr_reg == DEPTH_P - PTR_ONE) ? {PTR_W{1'b0}} :
                    wr_ptr_reg + PTR_ONE;
      if (count_reg != DEPTH_P)
        count_reg <= count_reg + PTR_ONE;
      nv_info_reg <= info_word;
      nv_cnt_reg <= cnt_word;
      nv_stamp_reg <= stamp_reg;
      nv_dur_reg <= dur_word;
      nv_ttt_reg <= ttt_reg;
      nv_meas_reg <= meas_word;
    end
  end

  // ************************************************************
  // Display notification, set wins over clear
  // ************************************************************
  wire note_clr = psel & penable & pready & pwrite & (paddr == `REG_NOTE_CLR) &
                  pwdata[`STAT_NOTE_BIT];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      notify <= 1'b0;
    else if (commit)
      notify <= 1'b1;
    else if (note_clr)
      notify <= 1'b0;
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  wire [PTR_W-1:0] sel_idx = select_reg[PTR_W-1:0];
  wire [PTR_W:0] back_sum = {1'b0, wr_ptr_reg} + {1'b0, DEPTH_P} - {1'b0, PTR_ONE} -
                            {1'b0, sel_idx};
  wire [PTR_W-1:0] rd_ptr = (back_sum >= {1'b0, DEPTH_P}) ?
                            back_sum[PTR_W-1:0] - DEPTH_P : back_sum[PTR_W-1:0];
  wire nv_sel = select_reg[`SEL_NV_BIT];
  wire rec_ok = (sel_idx < count_reg) & (select_reg[`SEL_IDX_MSB:PTR_W] == 2'b00);
  reg [31:0] rd_data;
  reg rd_err;

  always @*
  begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `REG_CTRL: rd_data[`CTRL_MODE_BIT] = mode_reg;
      `REG_DELAY: rd_data[15:0] = delay_reg;
      `REG_STATUS:
      begin
        rd_data[`STAT_CNT_LSB +: PTR_W] = count_reg;
        rd_data[`STAT_NOTE_BIT] = notify;
        rd_data[`STAT_BUSY_BIT] = (state_reg != S_IDLE);
      end
      `REG_NOTE_CLR: rd_data = 32'h00000000;
      `REG_SELECT: rd_data[7:0] = select_reg;
      `REG_INFO: rd_data = nv_sel ? nv_info_reg : (rec_ok ? info_mem[rd_ptr] : 32'h00000000);
      `REG_COUNTS: rd_data = nv_sel ? nv_cnt_reg : (rec_ok ? cnt_mem[rd_ptr] : 32'h00000000);
      `REG_STAMP: rd_data = nv_sel ? nv_stamp_reg : (rec_ok ? stamp_mem[rd_ptr] : 32'h00000000);
      `REG_DUR: rd_data = nv_sel ? nv_dur_reg : (rec_ok ? dur_mem[rd_ptr] : 32'h00000000);
      `REG_TTT: rd_data = nv_sel ? nv_ttt_reg : (rec_ok ? ttt_mem[rd_ptr] : 32'h00000000);
      `REG_MEAS: rd_data = nv_sel ? nv_meas_reg : (rec_ok ? meas_mem[rd_ptr] : 32'h00000000);
      `REG_SEQ: rd_data = {grid_reg, seq_reg};
      default: rd_err = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      mode_reg <= `CTRL_RESET;
      delay_reg <= `DELAY_RESET;
      select_reg <= 8'h00;
    end
    else
    begin
      pready <= psel & ~penable & ~pready;
      if (psel && !penable)
      begin
        prdata <= pwrite ? 32'h00000000 : rd_data;
        pslverr <= rd_err;
      end
      else if (pready)
      begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
      if (psel && penable && pready && pwrite && !rd_err)
      begin
        case (paddr)
          `REG_CTRL: mode_reg <= pwdata[`CTRL_MODE_BIT];
          `REG_DELAY: delay_reg <= pwdata[15:0];
          `REG_SELECT: select_reg <= pwdata[7:0];
          default: select_reg <= select_reg;
        endcase
      end
    end
  end

endmodule

// ### core/fault_rec_defs.vh
// Constants for the fault event recorder: register map, fields, reset values, timing
`ifndef FAULT_REC_DEFS_VH
`define FAULT_REC_DEFS_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define REG_CTRL 8'h00
`define REG_DELAY 8'h04
`define REG_STATUS 8'h08
`define REG_NOTE_CLR 8'h0C
`define REG_SELECT 8'h10
`define REG_INFO 8'h14
`define REG_COUNTS 8'h18
`define REG_STAMP 8'h1C
`define REG_DUR 8'h20
`define REG_TTT 8'h24
`define REG_MEAS 8'h28
`define REG_SEQ 8'h2C

// ************************************************************
// Field positions
// ************************************************************
`define CTRL_MODE_BIT 0
`define STAT_NOTE_BIT 8
`define STAT_BUSY_BIT 9
`define STAT_CNT_LSB 0
`define SEL_NV_BIT 7
`define SEL_IDX_MSB 6
`define INFO_PU_LSB 0
`define INFO_TR_LSB 8
`define INFO_TRIPPED_BIT 16
`define INFO_TTT_OK_BIT 17
`define INFO_SET_LSB 20
`define INFO_ADAPT_LSB 24
`define INFO_ADAPT_USED_BIT 28
`define CNT_GRID_LSB 16

// ************************************************************
// Reset values
// ************************************************************
`define CTRL_RESET 1'b1
`define DELAY_RESET 16'h0000
`define SEQ_RESET 16'h0000

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS 10
`define TICK_NS 1000000
`define REC_DEPTH 20

`endif

// ### dv/fault_src.sv
// Protection module model driving pickup and trip levels
`timescale 1ns/1ps
module fault_src #(parameter N_MOD = 16)(
  input wire pclk,
  output logic [N_MOD-1:0] pickup_in,
  output logic [N_MOD-1:0] trip_in
);
  initial
  begin
    pickup_in = '0;
    trip_in = '0;
  end
  // ********
  // One episode, second module joins later, tr >= N_MOD means no trip
  // ********
  task automatic run(input int pu, pu2, tr, ta, len);
    int i;
    for (i = 0; i < len; i++)
    begin
      pickup_in <= (N_MOD'(1) << pu) | ((i >= 2) ? (N_MOD'(1) << pu2) : '0);
      trip_in <= (i >= ta && tr < N_MOD) ? (N_MOD'(1) << tr) : '0;
      @(posedge pclk);
    end
    pickup_in <= '0;
    trip_in <= '0;
    @(posedge pclk);
  endtask
endmodule

// ### dv/fault_event_recorder_asserts.sv
// Port checker for the fault event recorder
`timescale 1ns/1ps
`include "fault_rec_defs.vh"
module fer_chk #(parameter N_MOD = 16)(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [N_MOD-1:0] pickup_in,
  input wire [N_MOD-1:0] trip_in,
  input wire comb_pickup,
  input wire comb_trip,
  input wire notify
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire any_pu = |pickup_in;
  wire any_tr = |trip_in;
  wire clr = psel && penable && pwrite && paddr == `REG_NOTE_CLR && pwdata[8];
  wire bad = paddr > 8'h2C || paddr[1:0] != 2'b00;
  property p_cpu; comb_pickup == $past(any_pu); endproperty
  a_cpu: assert property (p_cpu) else $error("combined pickup wrong");
  property p_ctr; comb_trip == $past(any_tr); endproperty
  a_ctr: assert property (p_ctr) else $error("combined trip wrong");
  property p_ntf; $rose(notify) |-> !comb_pickup; endproperty
  a_ntf: assert property (p_ntf) else $error("notify before pickup end");
  property p_nhold; notify && !clr |=> notify; endproperty
  a_nhold: assert property (p_nhold) else $error("notify lost");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready too long");
  property p_err; psel && !penable && bad |=> pslverr && pready; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_err2; pslverr |-> pready; endproperty
  a_err2: assert property (p_err2) else $error("error without ready");
  property p_rd0; !pready |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data not idle");
endmodule
bind fault_event_recorder fer_chk #(.N_MOD(N_MOD)) u_fer_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pickup_in(pickup_in),
  .trip_in(trip_in), .comb_pickup(comb_pickup), .comb_trip(comb_trip),
  .notify(notify));

// ### dv/fault_event_recorder_tb_top.sv
// Self-checking bench for the fault event recorder
`timescale 1ns/1ps
`include "fault_rec_defs.vh"
module fault_event_recorder_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, cyc = 32'h0, prdata, rd;
  logic pready, pslverr, comb_pickup, comb_trip, notify, err;
  logic [15:0] pickup_in, trip_in;
  logic [1:0] pset = 2'h0;
  logic [3:0] agrp = 4'h0;
  logic aused = 1'b0, ar = 1'b0;
  logic [31:0] r [0:5];
  int error_cnt = 0, comparisons = 0, seq = 0, grid = 0, cnt = 0;
  int t0, i, k, c;
  int rows [0:4][0:6] = '{'{2, 5, 2, 12, 40, 1, 0}, '{3, 3, 7, 8, 24, 1, 1},
    '{9, 9, 16, 0, 20, 1, 0}, '{4, 4, 16, 0, 20, 0, 0}, '{1, 8, 1, 4, 16, 0, 0}};
  int rst [0:4][0:1] = '{'{`REG_CTRL, 1}, '{`REG_DELAY, 0}, '{`REG_SELECT, 0},
    '{`REG_STATUS, 0}, '{`REG_SEQ, 0}};
  wire [31:0] stamp = cyc ^ 32'h5A00_0000;
  initial
  begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 32'h1;
  fault_event_recorder #(.TICK_CYCLES(4)) u_fault_event_recorder (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pickup_in(pickup_in),
    .trip_in(trip_in), .meas_in(cyc), .time_base(stamp), .param_set(pset),
    .active_adaptive_group(agrp), .adaptive_used(aused), .auto_reclose(ar),
    .comb_pickup(comb_pickup), .comb_trip(comb_trip), .notify(notify));
  fault_src u_fault_src (.pclk(pclk), .pickup_in(pickup_in), .trip_in(trip_in));
  // ********
  // Helpers
  // ********
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rng(input string n, input logic [31:0] s, input int lo, input int hi);
    chk(n, {31'h0, s >= lo && s <= hi}, 32'h1);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    chk("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rec(input logic [7:0] s);
    int j;
    apb(1'b1, `REG_SELECT, {24'h0, s});
    for (j = 0; j < 6; j++)
    begin
      apb(1'b0, `REG_INFO + 8'(4 * j), 32'h0);
      r[j] = rd;
    end
  endtask
  task automatic ep(input int pu, pu2, tr, ta, len, input logic a);
    ar <= a;
    seq++;
    if (!a) grid++;
    @(posedge pclk);
    t0 = cyc;
    u_fault_src.run(pu, pu2, tr, ta, len);
    repeat (4) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #500000;
    error_cnt++;
    give_verdict();
  end
  // ********
  // Main sequence
  // ********
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 5; i++)
    begin
      pset <= 2'(i);
      agrp <= 4'(i + 3);
      aused <= i[0];
      apb(1'b1, `REG_CTRL, 32'(rows[i][5]));
      k = rows[i][2] < 16;
      c = k || rows[i][5];
      ep(rows[i][0], rows[i][1], rows[i][2], rows[i][3], rows[i][4], rows[i][6] != 0);
      cnt += c;
      chk("notify", {31'h0, notify}, 32'(c));
      apb(1'b0, `REG_STATUS, 32'h0);
      chk("count", {27'h0, rd[4:0]}, 32'(cnt));
      apb(1'b1, `REG_NOTE_CLR, 32'h100);
      chk("clear", {31'h0, notify}, 32'h0);
      if (c)
      begin
        rec(8'h00);
        chk("info", r[0], {3'h0, aused, aused ? agrp : 4'h0, 2'h0, pset, 2'h0,
          1'(k && rows[i][0] == rows[i][2]), 1'(k), 4'h0, k ? 4'(rows[i][2]) : 4'h0,
          4'h0, 4'(rows[i][0])});
        chk("counts", r[1], {16'(grid), 16'(seq)});
        chk("stamp", r[2], 32'(t0 + 1) ^ 32'h5A00_0000);
        rng("dur", r[3], rows[i][4] / 4 - 1, rows[i][4] / 4 + 1);
        if (k) chk("meas", r[5], 32'(t0 + rows[i][3] + 1));
        if (k && rows[i][0] == rows[i][2])
          rng("ttt", r[4], rows[i][3] / 4 - 1, rows[i][3] / 4 + 1);
      end
    end
    apb(1'b1, `REG_CTRL, 32'h1);
    apb(1'b1, `REG_DELAY, 32'h2);
    ep(6, 6, 6, 8, 60, 1'b0);
    cnt++;
    rec(8'h00);
    rng("meas_dly", r[5], t0 + 13, t0 + 18);
    // Pickup ends before the delayed capture: record waits for the snapshot
    apb(1'b1, `REG_NOTE_CLR, 32'h100);
    ep(5, 5, 5, 4, 6, 1'b0);
    cnt++;
    repeat (8) @(posedge pclk);
    chk("notify_wait", {31'h0, notify}, 32'h1);
    rec(8'h00);
    rng("meas_wait", r[5], t0 + 10, t0 + 13);
    chk("wait_tripped", {31'h0, r[0][16]}, 32'h1);
    chk("wait_counts", r[1], {16'(grid), 16'(seq)});
    apb(1'b1, `REG_DELAY, 32'h0);
    for (i = 0; i < 22; i++)
    begin
      ep(0, 0, 16, 0, 6, 1'b0);
    end
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("full", {27'h0, rd[4:0]}, 32'd20);
    rec(8'd19);
    chk("oldest", {16'h0, r[1][15:0]}, 32'(seq - 19));
    rec(8'd20);
    chk("beyond", r[0], 32'h0);
    rec(8'h80);
    chk("retained", r[1], {16'(grid), 16'(seq)});
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, `REG_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("ro", {27'h0, rd[4:0]}, 32'd20);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rst_notify", {31'h0, notify}, 32'h0);
    for (i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(rst[i][0]), 32'h0);
      chk("rst_reg", rd, 32'(rst[i][1]));
    end
    give_verdict();
  end
endmodule
